// File: design/dcc_pkg.sv
// ****************************************************************
// Shared constants for the dual comparator control block.
// ****************************************************************
package dcc_pkg;

  // ****************************************************************
  // Register bus geometry and register indices.
  // ****************************************************************
  localparam int unsigned ADDR_W      = 3;
  localparam int unsigned DATA_W      = 8;
  localparam logic [2:0]  REG_CTRL    = 3'h0;
  localparam logic [2:0]  REG_FLAGS   = 3'h1;
  localparam logic [2:0]  REG_CLEAR   = 3'h2;
  localparam logic [2:0]  REG_ENABLES = 3'h3;
  localparam logic [2:0]  REG_MAIN    = 3'h4;
  localparam logic [2:0]  REG_PORT    = 3'h5;

  // ****************************************************************
  // Field positions of the comparator control register.
  // ****************************************************************
  localparam int unsigned CTRL_CMP2_RESULT = 7;
  localparam int unsigned CTRL_CMP1_RESULT = 6;
  localparam int unsigned CTRL_CMP2_INVERT = 5;
  localparam int unsigned CTRL_CMP1_INVERT = 4;
  localparam int unsigned CTRL_INPUT_SW    = 3;
  localparam int unsigned CTRL_MODE_HI     = 2;
  localparam int unsigned CTRL_MODE_LO     = 0;
  localparam int unsigned CTRL_WR_HI       = 5;
  localparam logic [5:0]  CTRL_RESET       = 6'h00;

  // ****************************************************************
  // Interrupt related field positions.
  // ****************************************************************
  localparam int unsigned FLAG_CMP_IRQ  = 6;
  localparam int unsigned EN_CMP_IRQ    = 6;
  localparam int unsigned MAIN_GLOBAL   = 7;
  localparam int unsigned MAIN_PERIPH   = 6;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;

  // ****************************************************************
  // Mode field codes.
  // ****************************************************************
  localparam logic [2:0]  MODE_RESET_OFF = 3'b000;
  localparam logic [2:0]  MODE_MUX_REF   = 3'b110;
  localparam logic [2:0]  MODE_OFF       = 3'b111;

  // Modes that route the results onto the two pins, one bit per mode code.
  localparam logic [7:0]  PIN_OUT_MODES_DEF = 8'h28;

endpackage

// File: design/dcc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Two flip-flop synchroniser for signals from outside the clock.
// ****************************************************************
module dcc_sync
  import dcc_pkg::*;
#(
  parameter int unsigned W = 1
)(
  input  wire logic         sys_clk_i,
  input  wire logic         srst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds only the second stage to let metastability settle.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else if (ce_i)
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule
`default_nettype wire

// File: design/dcc_top.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_top
  import dcc_pkg::*;
#(
  parameter logic [7:0] PIN_OUT_MODES = PIN_OUT_MODES_DEF
)(
  input  wire logic              sys_clk_i,
  input  wire logic              srst_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              cmp1_raw_i,
  input  wire logic              cmp2_raw_i,
  input  wire logic [7:0]        port_f_pins_i,
  input  wire logic [7:0]        port_f_direction_i,
  input  wire logic [7:0]        analog_pin_config_i,
  output logic                   cmp_power_en_o,
  output logic                   ref_to_pos_o,
  output logic                   input_switch_o,
  output logic      [2:0]        cmp_mode_o,
  output logic                   pin_rf1_o,
  output logic                   pin_rf1_oe_o,
  output logic                   pin_rf2_o,
  output logic                   pin_rf2_oe_o,
  output logic                   irq_o,
  output logic                   wake_o
);

  // ****************************************************************
  // State.
  // ****************************************************************
  logic [5:0]        ctrl_q;
  logic [5:0]        ctrl_d;
  logic [1:0]        latched_q;
  logic [1:0]        latched_d;
  logic              flag_q;
  logic              flag_d;
  logic              cmp_irq_enable_q;
  logic              cmp_irq_enable_d;
  logic              global_irq_enable_q;
  logic              global_irq_enable_d;
  logic              peripheral_irq_enable_q;
  logic              peripheral_irq_enable_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              irq_q;
  logic              wake_q;
  logic              power_q;
  logic              ref_pos_q;
  logic              switch_q;
  logic [2:0]        mode_q;
  logic              rf1_q;
  logic              rf1_oe_q;
  logic              rf2_q;
  logic              rf2_oe_q;

  // ****************************************************************
  // Input synchronisers.
  // ****************************************************************
  logic [1:0] cmp_sync;
  logic [7:0] pins_sync;

  // Comparator decisions are asynchronous to the register clock.
  dcc_sync #(
    .W (2)
  ) u_cmp_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .async_i   ({cmp2_raw_i, cmp1_raw_i}),
    .sync_o    (cmp_sync)
  );

  // Port pins come straight from the pads.
  dcc_sync #(
    .W (8)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .async_i   (port_f_pins_i),
    .sync_o    (pins_sync)
  );

  // ****************************************************************
  // Control fields and mode decode.
  // ****************************************************************
  wire       cmp2_invert  = ctrl_q[CTRL_CMP2_INVERT];
  wire       cmp1_invert  = ctrl_q[CTRL_CMP1_INVERT];
  wire       input_switch = ctrl_q[CTRL_INPUT_SW];
  wire [2:0] cmp_mode_field = ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO];

  // Both the reset mode and the off mode leave the comparators unpowered.
  wire cmp_active  = (cmp_mode_field != MODE_RESET_OFF)
                   && (cmp_mode_field != MODE_OFF);
  wire mux_ref     = (cmp_mode_field == MODE_MUX_REF);
  wire pin_out_sel = PIN_OUT_MODES[cmp_mode_field];

  // ****************************************************************
  // Comparator results.
  // ****************************************************************
  // An inactive comparator decides low, so only the inversion shows.
  wire cmp1_result = (cmp_active & cmp_sync[0]) ^ cmp1_invert;
  wire cmp2_result = (cmp_active & cmp_sync[1]) ^ cmp2_invert;
  wire [1:0] results = {cmp2_result, cmp1_result};

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  wire wr_ctrl    = reg_wr_i && (reg_addr_i == REG_CTRL);
  wire rd_ctrl    = reg_rd_i && (reg_addr_i == REG_CTRL);
  wire wr_flags   = reg_wr_i && (reg_addr_i == REG_FLAGS);
  wire wr_clear   = reg_wr_i && (reg_addr_i == REG_CLEAR);
  wire wr_enables = reg_wr_i && (reg_addr_i == REG_ENABLES);
  wire wr_main    = reg_wr_i && (reg_addr_i == REG_MAIN);

  // ****************************************************************
  // Control register update.
  // ****************************************************************
  // Result bits are not stored, so written bits 7:6 are dropped; writes move results only through the invert and mode fields.
  assign ctrl_d = wr_ctrl ? reg_wdata_i[CTRL_WR_HI:0] : ctrl_q;

  // ****************************************************************
  // Change detector.
  // ****************************************************************
  // Any access of the control register takes a fresh snapshot. A change
  // landing in the same cycle as that access still meets the old snapshot,
  // so it raises the flag once; software must compare the results itself.
  wire ctrl_access = wr_ctrl | rd_ctrl;
  assign latched_d = ctrl_access ? results : latched_q;
  wire mismatch    = cmp_active && (results != latched_q);

  // ****************************************************************
  // Interrupt flag.
  // ****************************************************************
  // A write of one to the flag simulates an interrupt. Hardware set wins
  // over any clear, so a lasting mismatch keeps the flag up.
  wire flag_sw_set = wr_flags &  reg_wdata_i[FLAG_CMP_IRQ];
  wire flag_sw_clr = (wr_flags & ~reg_wdata_i[FLAG_CMP_IRQ])
                   | (wr_clear &  reg_wdata_i[FLAG_CMP_IRQ]);
  wire flag_set    = mismatch | flag_sw_set;
  assign flag_d    = flag_set ? 1'b1 : (flag_sw_clr ? 1'b0 : flag_q);

  // ****************************************************************
  // Enable registers.
  // ****************************************************************
  assign cmp_irq_enable_d = wr_enables ? reg_wdata_i[EN_CMP_IRQ]
                                       : cmp_irq_enable_q;
  assign global_irq_enable_d = wr_main ? reg_wdata_i[MAIN_GLOBAL]
                                       : global_irq_enable_q;
  assign peripheral_irq_enable_d = wr_main ? reg_wdata_i[MAIN_PERIPH]
                                           : peripheral_irq_enable_q;

  // The flag sets regardless; the request needs all three enables.
  wire irq_d  = flag_q & cmp_irq_enable_q
              & peripheral_irq_enable_q & global_irq_enable_q;
  // Wake needs only the comparator enable, as in sleep the core is halted.
  wire wake_d = flag_q & cmp_irq_enable_q;

  // ****************************************************************
  // Read data mux.
  // ****************************************************************
  wire [7:0] ctrl_rd  = {cmp2_result, cmp1_result, ctrl_q};
  wire [7:0] flags_rd = ZERO_BYTE | ({7'h00, flag_q} << FLAG_CMP_IRQ);
  wire [7:0] en_rd    = ZERO_BYTE | ({7'h00, cmp_irq_enable_q} << EN_CMP_IRQ);
  wire [7:0] main_rd  = ZERO_BYTE
                      | ({7'h00, global_irq_enable_q} << MAIN_GLOBAL)
                      | ({7'h00, peripheral_irq_enable_q} << MAIN_PERIPH);
  wire [7:0] port_rd  = pins_sync & ~analog_pin_config_i;

  // Unmapped and write-only addresses read as zero.
  always_comb
  begin
    rdata_d = ZERO_BYTE;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        REG_CTRL:    rdata_d = ctrl_rd;
        REG_FLAGS:   rdata_d = flags_rd;
        REG_ENABLES: rdata_d = en_rd;
        REG_MAIN:    rdata_d = main_rd;
        REG_PORT:    rdata_d = port_rd;
        default:     rdata_d = ZERO_BYTE;
      endcase
    end
  end

  // ****************************************************************
  // Pin output path.
  // ****************************************************************
  // The pins take the raw decision after one register only, so they
  // track the comparator ahead of the synchronised register view; the
  // price is that a pin may glitch once on a slow input edge.
  wire rf1_d    = (cmp_active & cmp1_raw_i) ^ cmp1_invert;
  wire rf2_d    = (cmp_active & cmp2_raw_i) ^ cmp2_invert;
  wire rf1_oe_d = pin_out_sel & ~port_f_direction_i[1];
  wire rf2_oe_d = pin_out_sel & ~port_f_direction_i[2];

  // ****************************************************************
  // Register state.
  // ****************************************************************
  // Device reset returns the control register to mode 000, comparators off.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      ctrl_q    <= CTRL_RESET;
      latched_q <= 2'b00;
      flag_q    <= 1'b0;
      rdata_q   <= ZERO_BYTE;
    end
    else if (ce_i)
    begin
      ctrl_q    <= ctrl_d;
      latched_q <= latched_d;
      flag_q    <= flag_d;
      rdata_q   <= rdata_d;
    end
  end

  // Enables.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      cmp_irq_enable_q        <= 1'b0;
      global_irq_enable_q     <= 1'b0;
      peripheral_irq_enable_q <= 1'b0;
    end
    else if (ce_i)
    begin
      cmp_irq_enable_q        <= cmp_irq_enable_d;
      global_irq_enable_q     <= global_irq_enable_d;
      peripheral_irq_enable_q <= peripheral_irq_enable_d;
    end
  end

  // Interrupt and wake outputs, registered to keep them glitch free.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_q  <= irq_d;
      wake_q <= wake_d;
    end
  end

  // Analog steering outputs and pin drivers.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      power_q   <= 1'b0;
      ref_pos_q <= 1'b0;
      switch_q  <= 1'b0;
      mode_q    <= MODE_RESET_OFF;
      rf1_q     <= 1'b0;
      rf2_q     <= 1'b0;
      rf1_oe_q  <= 1'b0;
      rf2_oe_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      power_q   <= cmp_active;
      ref_pos_q <= mux_ref;
      switch_q  <= mux_ref & input_switch;
      mode_q    <= cmp_mode_field;
      rf1_q     <= rf1_d;
      rf2_q     <= rf2_d;
      rf1_oe_q  <= rf1_oe_d;
      rf2_oe_q  <= rf2_oe_d;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign reg_rdata_o    = rdata_q;
  assign cmp_power_en_o = power_q;
  assign ref_to_pos_o   = ref_pos_q;
  assign input_switch_o = switch_q;
  assign cmp_mode_o     = mode_q;
  assign pin_rf1_o      = rf1_q;
  assign pin_rf1_oe_o   = rf1_oe_q;
  assign pin_rf2_o      = rf2_q;
  assign pin_rf2_oe_o   = rf2_oe_q;
  assign irq_o          = irq_q;
  assign wake_o         = wake_q;

endmodule
`default_nettype wire

// File: sim/dcc_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_checker
  import dcc_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              srst_i,
  input wire logic              ce_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic [7:0]        port_f_direction_i,
  input wire logic              cmp_power_en_o,
  input wire logic              ref_to_pos_o,
  input wire logic              input_switch_o,
  input wire logic [2:0]        cmp_mode_o,
  input wire logic              pin_rf1_oe_o,
  input wire logic              pin_rf2_oe_o,
  input wire logic              irq_o,
  input wire logic              wake_o
);
  // ****************************************************************
  // Helper state.
  // ****************************************************************
  logic [2:0] last_mode_q;
  logic       ctrl_wr;
  assign ctrl_wr = reg_wr_i && ce_i && (reg_addr_i == REG_CTRL);
  // The last written mode lets the delayed mode copy be judged either way it is staged.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      last_mode_q <= MODE_RESET_OFF;
    else if (ctrl_wr)
      last_mode_q <= reg_wdata_i[2:0];
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // ****************************************************************
  // Properties.
  // ****************************************************************
  rdata_idle_a: assert property ($past(ce_i) && !$past(reg_rd_i) |->
    reg_rdata_o == ZERO_BYTE) else $error("read data not zero outside read answer");
  reset_clear_a: assert property ($past(srst_i) |-> cmp_mode_o == MODE_RESET_OFF
    && !cmp_power_en_o && !irq_o && !wake_o) else $error("outputs not cleared by reset");
  power_mode_a: assert property (cmp_power_en_o ==
    (cmp_mode_o != MODE_RESET_OFF && cmp_mode_o != MODE_OFF)) else $error("power not per mode");
  ref_mode_a: assert property (ref_to_pos_o == (cmp_mode_o == MODE_MUX_REF))
    else $error("reference routing not per mode");
  switch_mode_a: assert property (input_switch_o |-> cmp_mode_o == MODE_MUX_REF)
    else $error("input switch outside mux mode");
  irq_needs_wake_a: assert property (irq_o |-> wake_o)
    else $error("request without comparator enable");
  rf1_dir_gate_a: assert property (pin_rf1_oe_o |-> !$past(port_f_direction_i[1]))
    else $error("RF1 driven while direction is input");
  rf2_dir_gate_a: assert property (pin_rf2_oe_o |-> !$past(port_f_direction_i[2]))
    else $error("RF2 driven while direction is input");
  mode_write_a: assert property ($past(ctrl_wr, 2) && !$past(ctrl_wr) |->
    cmp_mode_o == last_mode_q) else $error("mode output differs from written mode");
  cover property (irq_o);
  cover property (ref_to_pos_o && input_switch_o);
  cover property (pin_rf1_oe_o || pin_rf2_oe_o);
  cover property (wake_o && !irq_o);
endmodule
bind dcc_top dcc_checker dcc_checker_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
  .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .port_f_direction_i(port_f_direction_i),
  .cmp_power_en_o(cmp_power_en_o), .ref_to_pos_o(ref_to_pos_o),
  .input_switch_o(input_switch_o), .cmp_mode_o(cmp_mode_o), .pin_rf1_oe_o(pin_rf1_oe_o),
  .pin_rf2_oe_o(pin_rf2_oe_o), .irq_o(irq_o), .wake_o(wake_o));
`default_nettype wire

// File: sim/dcc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_top_tb_top;
  import dcc_pkg::*;
  localparam logic [7:0] PMODES = PIN_OUT_MODES_DEF;
  logic       sys_clk_i, srst_i, ce_i, reg_wr_i, reg_rd_i, cmp1_raw_i, cmp2_raw_i;
  logic [2:0] reg_addr_i, cmp_mode_o;
  logic [7:0] reg_wdata_i, reg_rdata_o, port_f_pins_i, port_f_direction_i, analog_pin_config_i;
  logic       cmp_power_en_o, ref_to_pos_o, input_switch_o, irq_o, wake_o;
  logic       pin_rf1_o, pin_rf1_oe_o, pin_rf2_o, pin_rf2_oe_o;
  logic [7:0] q, r, e;
  int         err_count, n_checks;
  dcc_top #(.PIN_OUT_MODES(PMODES)) dcc_top_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cmp1_raw_i(cmp1_raw_i),
    .cmp2_raw_i(cmp2_raw_i), .port_f_pins_i(port_f_pins_i),
    .port_f_direction_i(port_f_direction_i), .analog_pin_config_i(analog_pin_config_i),
    .cmp_power_en_o(cmp_power_en_o), .ref_to_pos_o(ref_to_pos_o),
    .input_switch_o(input_switch_o), .cmp_mode_o(cmp_mode_o), .pin_rf1_o(pin_rf1_o),
    .pin_rf1_oe_o(pin_rf1_oe_o), .pin_rf2_o(pin_rf2_o), .pin_rf2_oe_o(pin_rf2_oe_o),
    .irq_o(irq_o), .wake_o(wake_o));
  // ****************************************************************
  // Clock, bus tasks and expectations.
  // ****************************************************************
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // Read data is taken one step after the answering edge, where it has settled.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // Powered-off comparators read as their invert bits alone.
  function automatic logic [7:0] exp_ctrl(input logic [5:0] c, input logic c1, input logic c2);
    logic act;
    act = (c[2:0] != MODE_RESET_OFF) && (c[2:0] != MODE_OFF);
    return {(act & c2) ^ c[5], (act & c1) ^ c[4], c};
  endfunction
  function automatic logic [7:0] exp_outs(input logic [7:0] c, input logic [7:0] ev);
    logic mux;
    mux = (c[2:0] == MODE_MUX_REF);
    return {(c[2:0] != MODE_RESET_OFF) && (c[2:0] != MODE_OFF), mux, mux & c[3], c[2:0],
      ev[6], ev[7]};
  endfunction
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  initial
  begin
    {srst_i, ce_i, reg_wr_i, reg_rd_i, cmp1_raw_i, cmp2_raw_i} = 6'b11_0000;
    {reg_addr_i, reg_wdata_i, port_f_pins_i, port_f_direction_i, analog_pin_config_i} = '0;
    err_count = 0;
    n_checks = 0;
    void'($urandom(32'h2603_c2e2));
    repeat (16) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    for (int a = 0; a < 8; a++)
      rchk(3'(a), ZERO_BYTE);
    // Every mode three times, with random inverts and inputs; directions are zero on the first pass, random after.
    for (int i = 0; i < 24; i++)
    begin
      r = 8'($urandom());
      r[2:0] = 3'(i);
      r[3] = (i == 6) ? 1'b1 : r[3];
      @(posedge sys_clk_i);
      cmp1_raw_i <= 1'($urandom());
      cmp2_raw_i <= 1'($urandom());
      port_f_direction_i <= (i < 8) ? 8'h00 : 8'($urandom());
      wr(REG_CTRL, r);
      wait_n(4);
      e = exp_ctrl(r[5:0], cmp1_raw_i, cmp2_raw_i);
      chk({cmp_power_en_o, ref_to_pos_o, input_switch_o, cmp_mode_o, pin_rf1_o, pin_rf2_o},
        exp_outs(r, e));
      chk({6'h00, pin_rf2_oe_o, pin_rf1_oe_o}, {6'h00, PMODES[r[2:0]] & ~port_f_direction_i[2],
        PMODES[r[2:0]] & ~port_f_direction_i[1]});
      rchk(REG_CTRL, e);
    end
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rchk(REG_CTRL, ZERO_BYTE);
    // Change detection, relatch, clear, software set and the enable gates.
    @(posedge sys_clk_i);
    {cmp1_raw_i, cmp2_raw_i} <= 2'b00;
    wr(REG_CTRL, 8'h01);
    wait_n(4);
    rd(REG_CTRL, q);
    wr(REG_FLAGS, ZERO_BYTE);
    wr(REG_ENABLES, 8'h40);
    wr(REG_MAIN, 8'hC0);
    wait_n(3);
    chk({6'h00, irq_o, wake_o}, 8'h00);
    @(posedge sys_clk_i);
    cmp1_raw_i <= 1'b1;
    wait_n(5);
    chk({6'h00, irq_o, wake_o}, 8'h03);
    wr(REG_FLAGS, ZERO_BYTE);
    wait_n(3);
    rchk(REG_FLAGS, 8'h40);
    rd(REG_CTRL, q);
    wr(REG_FLAGS, ZERO_BYTE);
    wait_n(3);
    chk({6'h00, irq_o, wake_o}, 8'h00);
    wr(REG_FLAGS, 8'h40);
    wait_n(3);
    chk({6'h00, irq_o, wake_o}, 8'h03);
    wr(REG_MAIN, 8'h40);
    wait_n(3);
    chk({6'h00, irq_o, wake_o}, 8'h01);
    wr(REG_MAIN, 8'h80);
    wait_n(3);
    chk({6'h00, irq_o, wake_o}, 8'h01);
    wr(REG_CLEAR, 8'h40);
    wait_n(3);
    chk({6'h00, irq_o, wake_o}, 8'h00);
    wr(REG_ENABLES, ZERO_BYTE);
    @(posedge sys_clk_i);
    cmp2_raw_i <= 1'b1;
    wait_n(5);
    chk({6'h00, irq_o, wake_o}, 8'h00);
    rchk(REG_FLAGS, 8'h40);
    wr(REG_CTRL, 8'h07);
    wr(REG_FLAGS, ZERO_BYTE);
    @(posedge sys_clk_i);
    cmp1_raw_i <= 1'b0;
    wait_n(5);
    rchk(REG_FLAGS, ZERO_BYTE);
    // Pins configured as analog read back as zero.
    for (int i = 0; i < 6; i++)
    begin
      @(posedge sys_clk_i);
      port_f_pins_i <= 8'($urandom());
      analog_pin_config_i <= (i == 0) ? 8'hFF : 8'($urandom());
      wait_n(3);
      rchk(REG_PORT, port_f_pins_i & ~analog_pin_config_i);
    end
    // A low clock enable freezes all state, so a write made then is lost.
    wr(REG_CTRL, 8'h13);
    wait_n(3);
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    wr(REG_CTRL, 8'h25);
    @(posedge sys_clk_i);
    ce_i <= 1'b1;
    rchk(REG_CTRL, exp_ctrl(6'h13, cmp1_raw_i, cmp2_raw_i));
    report_and_stop();
  end
  // A hang is cut short well after the expected few hundred cycles.
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
